//--- hw/dcic_pkg.sv
// package for the dual card interface control block
// assumes a single 125 MHz core clock; no software-visible registers
package dcic_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 8;
    localparam int unsigned DEBOUNCE_MS     = 8;
    // debounce count: 8 ms at 8 ns per cycle
    localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned DEB_W           = 20;
    localparam int unsigned DIV_W           = 3;

    // divider select codes {hi, lo}
    localparam logic [1:0] DIV_SEL_BY8 = 2'h0;
    localparam logic [1:0] DIV_SEL_BY4 = 2'h1;
    localparam logic [1:0] DIV_SEL_BY2 = 2'h3;
    localparam logic [1:0] DIV_SEL_BY1 = 2'h2;

    // half-period lengths in crystal cycles minus one; by1 handled as pass-through
    localparam logic [DIV_W-1:0] HALF_BY8 = 3'h3;
    localparam logic [DIV_W-1:0] HALF_BY4 = 3'h1;
    localparam logic [DIV_W-1:0] HALF_BY2 = 3'h0;

    typedef enum logic [2:0] {
        DCIC_V_3V0 = 3'b001,
        DCIC_V_5V0 = 3'b010,
        DCIC_V_1V8 = 3'b100
    } dcic_volt_t;

    typedef struct packed {
        logic clk;
        logic rst;
        logic data;
        logic data_oe;
    } dcic_card_t;

endpackage

//--- hw/dcic_debounce.sv
// presence debouncer: input must stay high for the full count before reported
// assumes presence input already synchronous to core_clk_in
`timescale 1ns/1ps
module dcic_debounce #(
    parameter int unsigned COUNT = dcic_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic presence_in,
    output logic      present_out
);
    logic [dcic_pkg::DEB_W-1:0] cnt_q;
    logic                       present_q;
    wire                        done = (cnt_q == dcic_pkg::DEB_W'(COUNT - 1));

    // removal is reported at once; only insertion is delayed
    always_ff @(posedge core_clk_in) begin
        if (rst_in || !presence_in) begin
            cnt_q     <= '0;
            present_q <= 1'b0;
        end else if (!present_q) begin
            if (done) begin
                present_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign present_out = present_q;

    property p_deb_hold;
        @(posedge core_clk_in) disable iff (rst_in)
        $rose(present_q) |-> $past(presence_in) && (cnt_q == dcic_pkg::DEB_W'(COUNT - 1));
    endproperty
    a_deb_hold : assert property (p_deb_hold)
        else $error("presence reported too early");
endmodule // dcic_debounce

//--- hw/dcic_top.sv
// dual card interface control: divider, voltage select, presence, routing
// assumes all host inputs synchronous to core_clk_in, which is the crystal clock
// Operation
// - card clock is crystal divided by 1, 2, 4 or 8 per select pins
// - voltage select high picks 5V supply, low picks 3V
// - low-voltage select overrides the CARD_VOLTAGE_SELECT select
// - low-voltage select high enters 1.8V card mode
// - low-voltage select at activation sets the activated interface supply to 1.8V; a later change leaves a live card's supply as it was
// - first presence active high, debounced 8 ms before reporting
// - first presence goes to selected status if A selected, else unselected status
// - second presence active high, debounced 8 ms before reporting
// - second presence goes to selected status if B selected, else unselected status
// - data line A active only when A selected and activated
// - data line B active only when B selected and activated
// - activation request low activates the selected interface
// - host card reset passes to the selected interface reset output while that interface is activated
// - host controls route to A when select low, B when high
// - unselected status reflects presence of the non-selected interface
// - selected status output is active low, an interrupt to host
// - divider changes synchronously, no runt pulses on change except one when leaving divide-by-1
`timescale 1ns/1ps
module dcic_top #(
    parameter int unsigned DEBOUNCE_COUNT = dcic_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        clock_divider_select_hi_in,
    input  wire logic        clock_divider_select_lo_in,
    input  wire logic        card_voltage_select_in,
    input  wire logic        low_voltage_card_select_in,
    input  wire logic        interface_select_in,
    input  wire logic        activation_request_n_in,
    input  wire logic        host_card_reset_in,
    input  wire logic        host_data_line_in,
    input  wire logic        presence_in_first_in,
    input  wire logic        presence_in_second_in,
    input  wire logic        card_data_first_in,
    input  wire logic        card_data_second_in,
    output logic             host_data_line_out,
    output logic             card_clock_first_out,
    output logic             card_clock_second_out,
    output logic             card_reset_first_out,
    output logic             card_reset_second_out,
    output logic             card_data_first_out,
    output logic             card_data_first_oe_out,
    output logic             card_data_second_out,
    output logic             card_data_second_oe_out,
    output logic [2:0]       supply_select_first_out,
    output logic [2:0]       supply_select_second_out,
    output logic             selected_status_n_out,
    output logic             unselected_status_out
);

    ////////////////////////////////////////////////////////////////////////////
    // supply voltage decode
    dcic_pkg::dcic_volt_t volt_sel;
    assign volt_sel = low_voltage_card_select_in ? dcic_pkg::DCIC_V_1V8 :
                      card_voltage_select_in     ? dcic_pkg::DCIC_V_5V0 :
                                                   dcic_pkg::DCIC_V_3V0;

    ////////////////////////////////////////////////////////////////////////////
    // activation state per interface; the sequencer timing itself is external
    logic act_a_q;
    logic act_b_q;
    logic [2:0] volt_a_q;
    logic [2:0] volt_b_q;
    wire  req      = !activation_request_n_in;
    wire  sel_b    = interface_select_in;
    wire  act_a_d  = sel_b ? act_a_q : req;
    wire  act_b_d  = sel_b ? req : act_b_q;

    // the voltage is latched at activation so a stray pin change cannot
    // swing the supply of a live card
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            act_a_q  <= 1'b0;
            act_b_q  <= 1'b0;
            volt_a_q <= '0;
            volt_b_q <= '0;
        end else begin
            act_a_q  <= act_a_d;
            act_b_q  <= act_b_d;
            if (act_a_d && !act_a_q) begin
                volt_a_q <= volt_sel;
            end
            if (act_b_d && !act_b_q) begin
                volt_b_q <= volt_sel;
            end
        end
    end
    assign supply_select_first_out  = act_a_q ? volt_a_q : 3'h0;
    assign supply_select_second_out = act_b_q ? volt_b_q : 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // card clock divider: a free counter whose bits give /2,/4,/8; the new
    // ratio is applied only when all outputs are at a common low edge
    logic [dcic_pkg::DIV_W-1:0] div_cnt_q;
    logic [1:0]                 div_sel_q;
    logic                       div_clk_q;
    wire  [1:0]                 div_pins = {clock_divider_select_hi_in,
                                            clock_divider_select_lo_in};
    wire                        aligned  = (div_cnt_q == '1);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            div_cnt_q <= '0;
            div_sel_q <= dcic_pkg::DIV_SEL_BY8;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
            if (aligned) begin
                div_sel_q <= div_pins;
            end
        end
    end

    logic div_lvl;
    always_comb begin
        case (div_sel_q)
            dcic_pkg::DIV_SEL_BY2: div_lvl = div_cnt_q[0];
            dcic_pkg::DIV_SEL_BY4: div_lvl = div_cnt_q[1];
            dcic_pkg::DIV_SEL_BY8: div_lvl = div_cnt_q[2];
            default:               div_lvl = 1'b0;
        endcase
    end
    assign div_clk_q = div_lvl;
    // full rate passes the crystal itself; gating is only by activation level
    wire card_clk = (div_sel_q == dcic_pkg::DIV_SEL_BY1) ? core_clk_in : div_clk_q;

    ////////////////////////////////////////////////////////////////////////////
    // card outputs
    logic rst_a_q;
    logic rst_b_q;
    logic dat_a_q;
    logic dat_b_q;
    logic hdat_q;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
            dat_a_q <= 1'b0;
            dat_b_q <= 1'b0;
            hdat_q  <= 1'b1;
        end else begin
            rst_a_q <= act_a_q && !sel_b ? host_card_reset_in : rst_a_q && act_a_q;
            rst_b_q <= act_b_q && sel_b  ? host_card_reset_in : rst_b_q && act_b_q;
            dat_a_q <= host_data_line_in && act_a_q && !sel_b;
            dat_b_q <= host_data_line_in && act_b_q && sel_b;
            hdat_q  <= sel_b ? card_data_second_in : card_data_first_in;
        end
    end

    assign card_clock_first_out    = act_a_q && card_clk;
    assign card_clock_second_out   = act_b_q && card_clk;
    assign card_reset_first_out    = rst_a_q;
    assign card_reset_second_out   = rst_b_q;
    assign card_data_first_out     = dat_a_q;
    assign card_data_second_out    = dat_b_q;
    assign card_data_first_oe_out  = act_a_q && !sel_b;
    assign card_data_second_oe_out = act_b_q && sel_b;
    assign host_data_line_out      = hdat_q;

    ////////////////////////////////////////////////////////////////////////////
    // presence debounce and status routing
    logic pres_a;
    logic pres_b;
    dcic_debounce #(.COUNT(DEBOUNCE_COUNT)) u_deb_a (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .presence_in (presence_in_first_in),
        .present_out (pres_a)
    );
    dcic_debounce #(.COUNT(DEBOUNCE_COUNT)) u_deb_b (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .presence_in (presence_in_second_in),
        .present_out (pres_b)
    );
    assign selected_status_n_out = !(sel_b ? pres_b : pres_a);
    assign unselected_status_out = sel_b ? pres_a : pres_b;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_sel_status;
        @(posedge core_clk_in) disable iff (rst_in)
        !sel_b && pres_a |-> !selected_status_n_out;
    endproperty
    a_sel_status : assert property (p_sel_status) else $error("selected status wrong");

    property p_sel_status_b;
        @(posedge core_clk_in) disable iff (rst_in)
        sel_b && pres_b |-> !selected_status_n_out && (unselected_status_out == pres_a);
    endproperty
    a_sel_status_b : assert property (p_sel_status_b) else $error("status b wrong");

    property p_unsel;
        @(posedge core_clk_in) disable iff (rst_in)
        !sel_b |-> unselected_status_out == pres_b;
    endproperty
    a_unsel : assert property (p_unsel) else $error("unselected status wrong");

    property p_oe_a;
        @(posedge core_clk_in) disable iff (rst_in)
        card_data_first_oe_out |-> act_a_q && !interface_select_in;
    endproperty
    a_oe_a : assert property (p_oe_a) else $error("data a active wrongly");

    property p_oe_b;
        @(posedge core_clk_in) disable iff (rst_in)
        card_data_second_oe_out |-> act_b_q && interface_select_in;
    endproperty
    a_oe_b : assert property (p_oe_b) else $error("data b active wrongly");

    property p_act;
        @(posedge core_clk_in) disable iff (rst_in)
        !sel_b && !activation_request_n_in ##1 !sel_b |-> act_a_q;
    endproperty
    a_act : assert property (p_act) else $error("activation not taken");

    property p_idle_low;
        @(posedge core_clk_in) disable iff (rst_in)
        !act_a_q ##1 !act_a_q |-> !card_reset_first_out && !card_data_first_out;
    endproperty
    a_idle_low : assert property (p_idle_low) else $error("idle outputs not low");

    property p_lv;
        @(posedge core_clk_in) disable iff (rst_in)
        low_voltage_card_select_in |-> volt_sel == dcic_pkg::DCIC_V_1V8;
    endproperty
    a_lv : assert property (p_lv) else $error("low voltage not chosen");

    property p_div_sync;
        @(posedge core_clk_in) disable iff (rst_in)
        !$stable(div_sel_q) |-> $past(div_cnt_q) == '1;
    endproperty
    a_div_sync : assert property (p_div_sync) else $error("divider changed mid period");

    c_act_a  : cover property (@(posedge core_clk_in) $rose(act_a_q));
    c_act_b  : cover property (@(posedge core_clk_in) $rose(act_b_q));
    c_pres_a : cover property (@(posedge core_clk_in) $rose(pres_a));
    c_div    : cover property (@(posedge core_clk_in) !$stable(div_sel_q));
endmodule // dcic_top

//--- sim/dcic_card_model.sv
// one smart card socket: presence switch plus data line drive
// assumes the bench resolves the shared data wire from both enables
`timescale 1ns/1ps
module dcic_card_model (
    input  wire logic core_clk_in,
    input  wire logic present_cmd_in,
    input  wire logic reply_in,
    input  wire logic dut_oe_in,
    output logic      presence_out,
    output logic      data_out
);
    logic last_q;
    // presence switch is active high
    assign presence_out = present_cmd_in;
    // line toggles while the DUT drives it so a stale value never reads as valid
    assign data_out = dut_oe_in ? ~last_q : reply_in;
    always_ff @(posedge core_clk_in) begin
        last_q <= data_out;
    end
endmodule // dcic_card_model

//--- sim/tb_top.sv
// self-checking bench for the dual card interface control block
// assumes dcic_pkg and the hw files are compiled first
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned DEB = 16;
    logic core_clk_in = 1'b0, rst_in = 1'b1, div_hi = 1'b0, div_lo = 1'b0, cvs = 1'b0;
    logic lvs = 1'b0, sel = 1'b0, req_n = 1'b1, hrst = 1'b0, hdata = 1'b0;
    logic pres_a = 1'b0, pres_b = 1'b0, rep_a = 1'b0, rep_b = 1'b1;
    wire logic hd_o, clk_a, clk_b, rst_a, rst_b, d_a, oe_a, d_b, oe_b, sel_n, unsel;
    wire logic pa, pb, ca, cb;
    wire logic [2:0] sup_a, sup_b;
    typedef struct {int id; logic [31:0] exp;} dcic_note_t;
    dcic_note_t notes[$];
    event smp;
    int errors = 0, n_compared = 0, cyc = 0, edges = 0, edges_b = 0;
    logic [31:0] rng = 32'h0000_5fdc;
    string nm[13] = '{"sel_n", "unsel", "oe_a", "oe_b", "sup_a", "sup_b", "rst_a",
                      "data_a", "host_data", "clk_edges", "rst_b", "data_b", "clk_b_edges"};
    //////////////////////////////////////////////////////////////////////////
    always #4 core_clk_in = ~core_clk_in;
    always @(posedge clk_a) edges++;
    always @(posedge clk_b) edges_b++;
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    dcic_top #(.DEBOUNCE_COUNT(DEB)) dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .clock_divider_select_hi_in(div_hi), .clock_divider_select_lo_in(div_lo),
        .card_voltage_select_in(cvs), .low_voltage_card_select_in(lvs),
        .interface_select_in(sel), .activation_request_n_in(req_n),
        .host_card_reset_in(hrst), .host_data_line_in(hdata), .presence_in_first_in(pa),
        .presence_in_second_in(pb), .card_data_first_in(oe_a ? d_a : ca),
        .card_data_second_in(oe_b ? d_b : cb), .host_data_line_out(hd_o),
        .card_clock_first_out(clk_a), .card_clock_second_out(clk_b),
        .card_reset_first_out(rst_a), .card_reset_second_out(rst_b),
        .card_data_first_out(d_a), .card_data_first_oe_out(oe_a),
        .card_data_second_out(d_b), .card_data_second_oe_out(oe_b),
        .supply_select_first_out(sup_a), .supply_select_second_out(sup_b),
        .selected_status_n_out(sel_n), .unselected_status_out(unsel));
    dcic_card_model card_a (.core_clk_in(core_clk_in), .present_cmd_in(pres_a),
        .reply_in(rep_a), .dut_oe_in(oe_a), .presence_out(pa), .data_out(ca));
    dcic_card_model card_b (.core_clk_in(core_clk_in), .present_cmd_in(pres_b),
        .reply_in(rep_b), .dut_oe_in(oe_b), .presence_out(pb), .data_out(cb));
    //////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] seen(input int id);
        case (id)
            0: seen = {31'h0, sel_n};
            1: seen = {31'h0, unsel};
            2: seen = {31'h0, oe_a};
            3: seen = {31'h0, oe_b};
            4: seen = {29'h0, sup_a};
            5: seen = {29'h0, sup_b};
            6: seen = {31'h0, rst_a};
            7: seen = {31'h0, d_a};
            8: seen = {31'h0, hd_o};
            9: seen = edges;
            10: seen = {31'h0, rst_b};
            11: seen = {31'h0, d_b};
            default: seen = edges_b;
        endcase
    endfunction
    always begin : monitor
        dcic_note_t n;
        @(smp);
        while (notes.size() > 0) begin
            n = notes.pop_front();
            n_compared++;
            if (seen(n.id) !== n.exp) begin
                errors++;
                $display("BAD %s expected %0h seen %0h", nm[n.id], n.exp, seen(n.id));
            end
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    task automatic want(input int id, input logic [31:0] v);
        notes.push_back('{id, v});
    endtask
    task automatic check_now(input string t);
        ->smp;
        wait (notes.size() == 0);
        if (t != "") $display("test %s done", t);
    endtask
    task automatic activate(input logic s, input logic v5, input logic v18);
        req_n = 1'b1;
        tick(2);
        {sel, cvs, lvs} = {s, v5, v18};
        req_n = 1'b0; // host requests activation by pulling low
        tick(2);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    //////////////////////////////////////////////////////////////////////////
    initial begin : main
        logic [2:0] vt[4] = '{dcic_pkg::DCIC_V_5V0, dcic_pkg::DCIC_V_3V0,
                              dcic_pkg::DCIC_V_1V8, dcic_pkg::DCIC_V_1V8};
        logic [1:0] dc[4] = '{dcic_pkg::DIV_SEL_BY1, dcic_pkg::DIV_SEL_BY2,
                              dcic_pkg::DIV_SEL_BY4, dcic_pkg::DIV_SEL_BY8};
        tick(10);
        want(0, 1); want(1, 0); want(2, 0); want(4, 0); want(6, 0); want(8, 1);
        check_now("reset");
        rst_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            activate(1'b0, ~i[0], i[1]);
            want(2, 1); want(3, 0); want(4, vt[i]); want(5, 0);
            check_now("");
        end
        check_now("voltage");
        for (int i = 0; i < 12; i++) begin
            rng = xorshift(rng);
            {hrst, hdata} = rng[1:0];
            tick(2);
            want(6, rng[1]); want(7, rng[0]);
            check_now("");
        end
        for (int i = 0; i < 4; i++) begin
            {div_hi, div_lo} = dc[i];
            tick(24);
            edges = 0;
            tick(64);
            want(9, 64 >> i);
            check_now("");
        end
        check_now("routing and divider");
        req_n = 1'b1; // the other interface is not activated here
        sel = 1'b1;
        tick(3);
        want(2, 0); want(3, 0); want(5, 0);
        check_now("");
        rep_a = rng[5];
        rep_b = ~rng[5];
        sel = 1'b0;
        tick(3);
        want(2, 0); want(8, rng[5]);
        check_now("");
        sel = 1'b1;
        tick(2);
        want(8, {31'h0, ~rng[5]});
        check_now("select");
        activate(1'b1, 1'b0, 1'b0);
        want(3, 1); want(2, 0); want(5, dcic_pkg::DCIC_V_3V0);
        check_now("");
        for (int i = 0; i < 6; i++) begin
            rng = xorshift(rng);
            {hrst, hdata} = rng[1:0];
            tick(2);
            want(10, rng[1]); want(11, rng[0]); want(6, 0);
            check_now("");
        end
        edges_b = 0;
        tick(64);
        want(12, 8);
        req_n = 1'b1;
        check_now("card b");
        sel = 1'b0;
        pres_a = 1'b1;
        tick(DEB - 6);
        pres_a = 1'b0;
        tick(DEB);
        want(0, 1); want(1, 0);
        check_now("");
        pres_a = 1'b1;
        tick(DEB - 3);
        want(0, 1);
        check_now("");
        tick(5);
        want(0, 0); want(1, 0);
        check_now("");
        pres_b = 1'b1;
        tick(DEB + 2);
        want(0, 0); want(1, 1);
        check_now("");
        sel = 1'b1;
        tick(2);
        want(0, 0); want(1, 1);
        check_now("");
        pres_a = 1'b0;
        tick(3);
        want(0, 0); want(1, 0);
        check_now("presence");
        results();
    end
endmodule // tb_top
